/* design/dram_pd_zq_map.svh */
// timing constants and encodings for the power-down and calibration block
// assumes a 50 MHz command clock (20 ns period)
`ifndef DRAM_PD_ZQ_MAP_SVH
`define DRAM_PD_ZQ_MAP_SVH
`define CLK_PERIOD_NS 20
// calibration windows in clock cycles
`define ZQ_INIT_CYC 12'd512
`define ZQ_OPER_CYC 12'd256
`define ZQ_SHORT_CYC 12'd64
// command encodings {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_ACT 4'h3
`define CMD_PRE 4'h2
`define CMD_ZQ 4'h6
`define CMD_MRS 4'h0
// mode register zero write recovery field
`define MR0_WR_LSB 9
`define MR0_WR_W 3
`define NUM_BANKS 8
`define ZQ_LONG_BIT 10
`endif

/* design/dram_pd_zq_pkg.sv */
// types shared by the power-down and calibration block
// assumes dram_pd_zq_map.svh supplies the numeric constants
package dram_pd_zq_pkg;
    typedef enum logic [3:0] {
        CAL_IDLE = 4'b0001,
        CAL_RUN = 4'b0010,
        CAL_XFER = 4'b0100,
        CAL_DONE = 4'b1000
    } cal_state_e;
    typedef logic [11:0] cal_count_t;
endpackage

/* design/zq_engine.sv */
// calibration engine: counts a window and transfers results to io
// assumes start pulses arrive only while idle
`timescale 1ns/1ps
`include "dram_pd_zq_map.svh"
module zq_engine import dram_pd_zq_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic start,
    input wire logic isLong,
    output logic busy,
    output logic xferPulse,
    output logic currentOn
);
    cal_state_e state;
    cal_state_e next_state;
    cal_count_t count;
    cal_count_t next_count;
    logic firstLong;
    logic next_firstLong;

    always_comb begin
        next_state = state;
        next_count = count;
        next_firstLong = firstLong;
        unique case (state)
            CAL_IDLE: begin
                if (start) begin
                    next_state = CAL_RUN;
                    // first long run after reset gets the longer window
                    // short by four: transfer, done and the output flop must still fit inside the window
                    if (isLong) begin
                        next_count = firstLong ? `ZQ_INIT_CYC - 12'd4 : `ZQ_OPER_CYC - 12'd4;
                        next_firstLong = 1'b0;
                    end else begin
                        next_count = `ZQ_SHORT_CYC - 12'd4;
                    end
                end
            end
            CAL_RUN: begin
                if (count == 12'h000) begin
                    next_state = CAL_XFER;
                end else begin
                    next_count = count - 12'd1;
                end
            end
            CAL_XFER: next_state = CAL_DONE;
            CAL_DONE: next_state = CAL_IDLE;
            default: next_state = CAL_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= CAL_IDLE;
            count <= 12'h000;
            firstLong <= 1'b1;
        end else if (clkEn) begin
            state <= next_state;
            count <= next_count;
            firstLong <= next_firstLong;
        end
    end

    assign busy = (state != CAL_IDLE);
    assign xferPulse = (state == CAL_XFER);
    // reference current path only while measuring
    assign currentOn = (state == CAL_RUN);
endmodule

/* design/dram_pd_zq.sv */
// What this block does
// - long calibration updates driver and termination
// - first long gets init window, later operating
// - short calibration finishes within its window
// - calibration current switched off once done
// - no self-started recalibration after self-refresh
// - data drivers high impedance during calibration
// - write recovery taken from mode register zero
// - cke low/high with nop enters/exits power-down, no entry while calibrating
// - closed banks precharge mode, else active mode
//
// device-side power-down tracking and calibration control
// assumes the controller keeps its own timing obligations
`timescale 1ns/1ps
`include "dram_pd_zq_map.svh"
module dram_pd_zq import dram_pd_zq_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic cke,
    input wire logic [3:0] cmd,
    input wire logic [2:0] bankAddr,
    input wire logic [15:0] addr,
    input wire logic odt,
    output logic powerDown,
    output logic activePd,
    output logic prechargePd,
    output logic calBusy,
    output logic ioUpdate,
    output logic zqCurrentOn,
    output logic dqOe_n,
    output logic [2:0] writeRecovery,
    output logic [7:0] bankOpen
);
    logic ckePrev;
    logic next_ckePrev;
    logic [7:0] next_bankOpen;
    logic next_powerDown;
    logic next_activePd;
    logic next_prechargePd;
    logic [2:0] next_writeRecovery;
    logic engBusy;
    logic engXfer;
    logic engCur;
    logic calStart;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    function automatic logic isNop(input logic [3:0] c);
        isNop = (c == `CMD_NOP) || c[3];
    endfunction

    // only accepted when idle with cke steady high
    assign calStart = ckePrev && cke && (cmd == `CMD_ZQ) && !engBusy && !powerDown;

    // ----------------------------------------
    // bank and power-down state
    // ----------------------------------------
    always_comb begin
        next_ckePrev = cke;
        next_bankOpen = bankOpen;
        next_powerDown = powerDown;
        next_activePd = activePd;
        next_prechargePd = prechargePd;
        next_writeRecovery = writeRecovery;
        if (ckePrev && !isNop(cmd)) begin
            if (cmd == `CMD_ACT) begin
                next_bankOpen[bankAddr] = 1'b1;
            end else if (cmd == `CMD_PRE) begin
                if (addr[`ZQ_LONG_BIT]) begin
                    next_bankOpen = 8'h00;
                end else begin
                    next_bankOpen[bankAddr] = 1'b0;
                end
            end else if (cmd == `CMD_MRS && bankAddr == 3'h0) begin
                // write recovery held from mode register zero
                next_writeRecovery = addr[`MR0_WR_LSB +: `MR0_WR_W];
            end
        end
        // entry on cke falling with nop while the engine is idle, exit on rising with nop
        if (ckePrev && !cke && isNop(cmd) && !engBusy) begin
            next_powerDown = 1'b1;
            // mode chosen from bank state after entry command
            next_activePd = (next_bankOpen != 8'h00);
            next_prechargePd = (next_bankOpen == 8'h00);
        end else if (!ckePrev && cke && isNop(cmd)) begin
            next_powerDown = 1'b0;
            next_activePd = 1'b0;
            next_prechargePd = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ckePrev <= 1'b0;
            bankOpen <= 8'h00;
            powerDown <= 1'b0;
            activePd <= 1'b0;
            prechargePd <= 1'b0;
            writeRecovery <= 3'h0;
        end else if (clkEn) begin
            ckePrev <= next_ckePrev;
            bankOpen <= next_bankOpen;
            powerDown <= next_powerDown;
            activePd <= next_activePd;
            prechargePd <= next_prechargePd;
            writeRecovery <= next_writeRecovery;
        end
    end

    // ----------------------------------------
    // calibration
    // ----------------------------------------
    // engine starts only on an explicit command, never on self-refresh exit
    zq_engine engine (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .start(calStart),
        .isLong(addr[`ZQ_LONG_BIT]),
        .busy(engBusy),
        .xferPulse(engXfer),
        .currentOn(engCur)
    );

    logic next_calBusy;
    logic next_ioUpdate;
    logic next_zqCurrentOn;
    logic next_dqOe_n;

    always_comb begin
        next_calBusy = engBusy || calStart;
        next_ioUpdate = engXfer;
        next_zqCurrentOn = engCur || calStart;
        next_dqOe_n = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            calBusy <= 1'b0;
            ioUpdate <= 1'b0;
            zqCurrentOn <= 1'b0;
            dqOe_n <= 1'b1;
        end else if (clkEn) begin
            calBusy <= next_calBusy;
            ioUpdate <= next_ioUpdate;
            zqCurrentOn <= next_zqCurrentOn;
            dqOe_n <= next_dqOe_n;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // checker-only memory of a taken long command, re-armed by reset
    logic longSeen;
    logic next_longSeen;

    always_comb begin
        next_longSeen = longSeen || (calStart && addr[`ZQ_LONG_BIT]);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            longSeen <= 1'b0;
        end else if (clkEn) begin
            longSeen <= next_longSeen;
        end
    end

    // windows run from the taking edge to the edge that samples ioUpdate high
    short_window_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && calStart && !addr[`ZQ_LONG_BIT]) |-> ##[1:64] (clkEn && ioUpdate))
        else $error("short calibration overran window");
    long_update_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && calStart && addr[`ZQ_LONG_BIT] && !longSeen) |-> ##[1:512] ioUpdate)
        else $error("first long calibration overran window");
    long_oper_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && calStart && addr[`ZQ_LONG_BIT] && longSeen) |-> ##[1:256] ioUpdate)
        else $error("long calibration overran operating window");
    xfer_after_run_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(ioUpdate) |-> $past(zqCurrentOn, 2))
        else $error("io update without measurement");
    current_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!calBusy) |-> !zqCurrentOn)
        else $error("calibration current left on");
    no_self_cal_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && !engBusy && !calStart) |=> !engBusy)
        else $error("calibration started unprompted");
    pd_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && ckePrev && !cke && isNop(cmd) && !engBusy) |=> powerDown)
        else $error("power-down entry missed");
    pd_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && !ckePrev && cke && isNop(cmd)) |=> !powerDown)
        else $error("power-down exit missed");
    pd_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
        powerDown |-> (activePd == (bankOpen != 8'h00)) && (activePd != prechargePd))
        else $error("wrong power-down mode");
    wr_recovery_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clkEn && ckePrev && cmd == `CMD_MRS && bankAddr == 3'h0)
        |=> writeRecovery == $past(addr[11:9]))
        else $error("write recovery not captured");
    dq_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        calBusy |-> dqOe_n)
        else $error("dq driven during calibration");

    long_cov_c: cover property (@(posedge ref_clk) calStart && addr[`ZQ_LONG_BIT]);
    short_cov_c: cover property (@(posedge ref_clk) calStart && !addr[`ZQ_LONG_BIT]);
    act_pd_c: cover property (@(posedge ref_clk) $rose(activePd));
    pre_pd_c: cover property (@(posedge ref_clk) $rose(prechargePd));
    quiet_cal_c: cover property (@(posedge ref_clk) calStart && !odt);
endmodule

/* tb/dram_ctrl_model.sv */
// controller-side partner: drives cke, odt and the command bus
// assumes one bench process calls its tasks in turn
`timescale 1ns/1ps
`include "dram_pd_zq_map.svh"
module dram_ctrl_model (
    input wire logic ref_clk,
    output logic cke,
    output logic [3:0] cmd,
    output logic [2:0] bankAddr,
    output logic [15:0] addr,
    output logic odt
);
    initial begin
        cke = 1'b1;
        cmd = `CMD_NOP;
        bankAddr = 3'h0;
        addr = 16'h0000;
        odt = 1'b0;
    end
    // one command, then nop; the released address flips so stale values never look valid
    task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a);
        @(posedge ref_clk);
        #1;
        cmd = c;
        bankAddr = ba;
        addr = a;
        @(posedge ref_clk);
        #1;
        cmd = `CMD_NOP;
        bankAddr = ~ba;
        addr = ~a;
    endtask
    // cke edge with nop, then held for the minimum pulse
    task automatic setCke(input logic v, input int hold);
        @(posedge ref_clk);
        #1;
        cke = v;
        cmd = `CMD_NOP;
        repeat (hold) @(posedge ref_clk);
        #1;
    endtask
endmodule

/* tb/tb.sv */
// bench: reference model against dram_pd_zq at every result
// assumes the design files and map header are compiled first
`timescale 1ns/1ps
`include "dram_pd_zq_map.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic ref_clk, rst, clkEn, cke, odt;
    logic [3:0] cmd;
    logic [2:0] bankAddr;
    logic [15:0] addr;
    logic powerDown, activePd, prechargePd, calBusy, ioUpdate, zqCurrentOn, dqOe_n;
    logic [2:0] writeRecovery;
    logic [7:0] bankOpen;
    int errors = 0;
    int nTests = 0;
    int cyc = 0;
    bit firstLong = 1;
    logic [7:0] openMask = 8'h00;
    logic [2:0] wr, b;
    dram_ctrl_model ctl_u (.ref_clk(ref_clk), .cke(cke), .cmd(cmd), .bankAddr(bankAddr),
        .addr(addr), .odt(odt));
    dram_pd_zq dut_u (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .cke(cke), .cmd(cmd),
        .bankAddr(bankAddr), .addr(addr), .odt(odt), .powerDown(powerDown), .activePd(activePd),
        .prechargePd(prechargePd), .calBusy(calBusy), .ioUpdate(ioUpdate),
        .zqCurrentOn(zqCurrentOn), .dqOe_n(dqOe_n), .writeRecovery(writeRecovery),
        .bankOpen(bankOpen));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic zqRun(input logic isLong);
        int win;
        int k;
        win = isLong ? (firstLong ? int'(`ZQ_INIT_CYC) : int'(`ZQ_OPER_CYC)) : int'(`ZQ_SHORT_CYC);
        if (isLong) firstLong = 0;
        ctl_u.issue(`CMD_ZQ, 3'h0, {5'h00, isLong, 10'h000});
        `CHK(calBusy, 1'b1)
        `CHK(zqCurrentOn, 1'b1)
        k = 1;
        while (ioUpdate !== 1'b1 && k < 1000) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        `CHK(k, win - 1)
        `CHK(zqCurrentOn, 1'b0)
        `CHK(dqOe_n, 1'b1)
        @(posedge ref_clk);
        #1;
        `CHK(ioUpdate, 1'b0)
        @(posedge ref_clk);
        #1;
        `CHK(calBusy, 1'b0)
        $display("zq test long=%0d window=%0d done", isLong, win);
    endtask
    task automatic pdRun();
        ctl_u.setCke(1'b0, 4);
        `CHK(powerDown, 1'b1)
        `CHK(activePd, openMask != 8'h00)
        `CHK(prechargePd, openMask == 8'h00)
        `CHK(bankOpen, openMask)
        ctl_u.setCke(1'b1, 4);
        `CHK(powerDown, 1'b0)
        $display("power-down test mask=%h done", openMask);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        void'($urandom(32'hf0e6874b));
        repeat (16) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        // short before any long must not consume the initial window
        zqRun(1'b0);
        zqRun(1'b1);
        zqRun(1'b1);
        zqRun(1'b0);
        b = 3'($urandom_range(7, 0));
        ctl_u.issue(`CMD_ACT, b, 16'($urandom));
        openMask = 8'h01 << b;
        pdRun();
        ctl_u.issue(`CMD_PRE, 3'h0, 16'h0400);
        openMask = 8'h00;
        pdRun();
        wr = 3'($urandom_range(7, 0));
        ctl_u.issue(`CMD_MRS, 3'h0, {4'h0, wr, 9'h000});
        `CHK(writeRecovery, wr)
        ctl_u.issue(`CMD_MRS, 3'h1, {4'h0, ~wr, 9'h000});
        `CHK(writeRecovery, wr)
        // clock enable low must freeze the captured code
        clkEn = 1'b0;
        ctl_u.issue(`CMD_MRS, 3'h0, {4'h0, ~wr, 9'h000});
        `CHK(writeRecovery, wr)
        clkEn = 1'b1;
        $display("write recovery test done");
        // second reset mid-run must re-arm the longer first window
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(calBusy, 1'b0)
        `CHK(writeRecovery, 3'h0)
        rst = 1'b0;
        firstLong = 1;
        zqRun(1'b1);
        close_out();
    end
    // bound is a few times the ~1460 cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            close_out();
        end
    end
endmodule
